// ---- hw/address_decode_bus_switch.sv ----
// Top: merges fetch and data ports, routes to targets, AHB-Lite status registers
//
// The placing of the registers and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
module address_decode_bus_switch #(
    parameter logic [31:0] ispace_base = bus_switch_pkg::ISPACE_BASE_DEF,
    parameter logic [31:0] dspace_base = bus_switch_pkg::DSPACE_BASE_DEF,
    parameter logic [31:0] internal_instr_mem_bytes = bus_switch_pkg::INTERNAL_INSTR_MEMORY_BYTES_DEF,
    parameter logic [31:0] internal_data_mem_bytes = bus_switch_pkg::INTERNAL_DATA_MEMORY_BYTES_DEF,
    parameter bit internal_instr_mem_present = 1'b0,
    parameter bit internal_data_mem_present = 1'b0,
    parameter bit external_bus_present = 1'b0,
    parameter bit boot_rom_present = 1'b1,
    parameter bit execute_in_place_unit = 1'b0,
    parameter logic [31:0] xip_base = 32'h2000_0000,
    parameter logic [31:0] xip_bytes = 32'h1000_0000,
    parameter logic [15:0] io_slot_present = 16'hFFFF
) (
    input wire logic hclk,
    input wire logic hresetn,
    // Instruction fetch port, request held until ack or err
    input wire logic i_valid,
    input wire bus_switch_pkg::bus_req_t i_req,
    output bus_switch_pkg::bus_rsp_t i_rsp,
    // Data access port, request held until ack or err
    input wire logic d_valid,
    input wire bus_switch_pkg::bus_req_t d_req,
    output bus_switch_pkg::bus_rsp_t d_rsp,
    // Shared internal bus toward the targets
    output bus_switch_pkg::bus_req_t tgt_req,
    output logic [bus_switch_pkg::NUM_TGT-1:0] tgt_sel,
    input wire bus_switch_pkg::bus_rsp_t tgt_rsp [bus_switch_pkg::NUM_TGT],
    // AHB-Lite register slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);
    // Switch states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_BUSY = 3'b010,
        ST_RESP = 3'b100
    } sw_state_t;

    sw_state_t st_q; // Access state
    bus_switch_pkg::bus_req_t req_sel; // Request of the port about to win
    bus_switch_pkg::bus_req_t tgt_req_q; // Request held toward targets
    logic [bus_switch_pkg::NUM_TGT-1:0] sel_dec; // Decoded target
    logic [bus_switch_pkg::NUM_TGT-1:0] tgt_sel_q; // Live select
    logic fault_dec; // Decode found no target
    bus_switch_pkg::bus_rsp_t hit; // Response of the selected target
    bus_switch_pkg::bus_rsp_t i_rsp_q; // Fetch port answer
    bus_switch_pkg::bus_rsp_t d_rsp_q; // Data port answer
    logic start; // A port wins this cycle
    logic start_data; // Winner is the data port
    logic owner_data_q; // Current owner is the data port
    logic [31:0] ctrl_q; // Control register
    logic [2:0] fstat_q; // Fault status
    logic [31:0] faddr_q; // Last faulting address
    logic [31:0] gcnt_q; // Routed access count
    logic fault_ev; // Decode fault or target error
    logic ahb_wr_q; // Write data phase pending
    logic [7:0] ahb_addr_q; // Register offset of that write
    logic ahb_rd; // Read address phase
    logic ahb_wr; // Write address phase

    // Winner selection; data comes first
    switch_arbiter u_arb (
        .hclk(hclk),
        .hresetn(hresetn),
        .idle(st_q == ST_IDLE),
        .d_valid(d_valid),
        .i_valid(i_valid),
        .i_allow(ctrl_q[bus_switch_pkg::CTRL_FETCH_EN]),
        .start(start),
        .start_data(start_data),
        .owner_data_q(owner_data_q)
    );

    // Both ports see the same map through one decoder
    always_comb begin
        req_sel = start_data ? d_req : i_req;
    end

    // No privilege input exists: user and machine accesses decode alike
    address_decoder #(
        .ispace_base(ispace_base),
        .dspace_base(dspace_base),
        .internal_instr_mem_bytes(internal_instr_mem_bytes),
        .internal_data_mem_bytes(internal_data_mem_bytes),
        .internal_instr_mem_present(internal_instr_mem_present),
        .internal_data_mem_present(internal_data_mem_present),
        .external_bus_present(external_bus_present),
        .boot_rom_present(boot_rom_present),
        .execute_in_place_unit(execute_in_place_unit),
        .xip_base(xip_base),
        .xip_bytes(xip_bytes),
        .io_slot_present(io_slot_present)
    ) u_dec (
        .addr(req_sel.addr),
        .we(req_sel.we),
        .be(req_sel.be),
        .sel(sel_dec),
        .fault(fault_dec)
    );

    // Pick the selected target's answer; selects are one-hot so OR is safe
    always_comb begin
        hit = '0;
        for (int k = 0; k < bus_switch_pkg::NUM_TGT; k++) begin
            if (tgt_sel_q[k]) begin
                hit = hit | tgt_rsp[k];
            end
        end
    end

    // Access sequencer: idle, wait on target, one answer cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= ST_IDLE;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    // Faults skip the target and answer directly
                    if (start) begin
                        st_q <= fault_dec ? ST_RESP : ST_BUSY;
                    end
                end
                ST_BUSY: begin
                    // Grant holds until the target ends it
                    if (hit.ack || hit.err) begin
                        st_q <= ST_RESP;
                    end
                end
                ST_RESP: begin
                    st_q <= ST_IDLE;
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Target request and select, from flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tgt_req_q <= '0;
            tgt_sel_q <= '0;
        end else if (st_q == ST_IDLE && start) begin
            tgt_req_q <= req_sel;
            tgt_sel_q <= fault_dec ? '0 : sel_dec;
        end else if (st_q == ST_BUSY && (hit.ack || hit.err)) begin
            tgt_sel_q <= '0;
        end
    end

    // Port answers: one-cycle pulse to the owner only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            i_rsp_q <= '0;
            d_rsp_q <= '0;
        end else begin
            i_rsp_q <= '0;
            d_rsp_q <= '0;
            if (st_q == ST_IDLE && start && fault_dec) begin
                // Decode fault is answered on the port that asked, data or fetch
                if (start_data) begin
                    d_rsp_q.err <= 1'b1;
                end else begin
                    i_rsp_q.err <= 1'b1;
                end
            end else if (st_q == ST_BUSY && (hit.ack || hit.err)) begin
                if (owner_data_q) begin
                    d_rsp_q <= hit;
                end else begin
                    i_rsp_q <= hit;
                end
            end
        end
    end

    assign tgt_req = tgt_req_q;
    assign tgt_sel = tgt_sel_q;
    assign i_rsp = i_rsp_q;
    assign d_rsp = d_rsp_q;

    // Fault event: decode miss or target error
    assign fault_ev = (st_q == ST_IDLE && start && fault_dec)
        || (st_q == ST_BUSY && hit.err);

    // AHB-Lite address phase decode
    assign ahb_rd = hsel && htrans[1] && hready && !hwrite;
    assign ahb_wr = hsel && htrans[1] && hready && hwrite;

    // Write data phase bookkeeping; zero wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ahb_wr_q <= 1'b0;
            ahb_addr_q <= 8'h00;
        end else if (hready) begin
            ahb_wr_q <= ahb_wr;
            ahb_addr_q <= haddr[7:0];
        end
    end

    // Control: fetch gate; clearing it starves the fetch port
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= bus_switch_pkg::CTRL_RST;
        end else if (ahb_wr_q && ahb_addr_q == bus_switch_pkg::REG_CTRL) begin
            ctrl_q <= {31'h0000_0000, hwdata[bus_switch_pkg::CTRL_FETCH_EN]};
        end
    end

    // Fault status; sticky seen bit, write one clears, a new fault wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fstat_q <= 3'h0;
            faddr_q <= 32'h0000_0000;
        end else begin
            if (fault_ev) begin
                fstat_q[bus_switch_pkg::FSTAT_SEEN] <= 1'b1;
                fstat_q[bus_switch_pkg::FSTAT_WRITE] <= (st_q == ST_IDLE) ? req_sel.we
                    : tgt_req_q.we;
                fstat_q[bus_switch_pkg::FSTAT_FETCH] <= (st_q == ST_IDLE) ? !start_data
                    : !owner_data_q;
                faddr_q <= (st_q == ST_IDLE) ? req_sel.addr : tgt_req_q.addr;
            end else if (ahb_wr_q && ahb_addr_q == bus_switch_pkg::REG_FSTAT
                && hwdata[bus_switch_pkg::FSTAT_SEEN]) begin
                fstat_q[bus_switch_pkg::FSTAT_SEEN] <= 1'b0;
            end
        end
    end

    // Count of accesses routed to a target; wraps silently
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gcnt_q <= 32'h0000_0000;
        end else if (st_q == ST_IDLE && start && !fault_dec) begin
            gcnt_q <= gcnt_q + 32'h0000_0001;
        end
    end

    // Read data registered in the address phase; unmapped reads return zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (ahb_rd) begin
            case (haddr[7:0])
                bus_switch_pkg::REG_CTRL: hrdata <= ctrl_q;
                bus_switch_pkg::REG_FSTAT: hrdata <= {29'h0000_0000, fstat_q};
                bus_switch_pkg::REG_FADDR: hrdata <= faddr_q;
                bus_switch_pkg::REG_GCNT: hrdata <= gcnt_q;
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Never stalls, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_busy_done;
        st_q == ST_BUSY && hit.ack;
    endsequence

    sequence s_io_narrow_write;
        st_q == ST_IDLE && start && req_sel.addr >= bus_switch_pkg::IO_BASE && req_sel.we
            && req_sel.be != bus_switch_pkg::BE_WORD;
    endsequence

    property p_one_target;
        $onehot0(tgt_sel_q) && !(st_q != ST_BUSY && tgt_sel_q != '0);
    endproperty
    a_one_target: assert property (p_one_target) else $error("select not one-hot");

    property p_data_first;
        st_q == ST_IDLE && d_valid && i_valid |=> owner_data_q && st_q != ST_IDLE;
    endproperty
    a_data_first: assert property (p_data_first) else $error("fetch beat data");

    property p_hold_grant;
        st_q == ST_BUSY && !(hit.ack || hit.err)
            |=> st_q == ST_BUSY && $stable(owner_data_q) && $stable(tgt_sel_q);
    endproperty
    a_hold_grant: assert property (p_hold_grant) else $error("grant dropped early");

    property p_no_ext_high;
        tgt_sel_q[bus_switch_pkg::T_EXT] |-> tgt_req_q.addr < bus_switch_pkg::BOOT_BASE;
    endproperty
    a_no_ext_high: assert property (p_no_ext_high) else $error("high address external");

    property p_io_narrow;
        s_io_narrow_write |=> st_q == ST_RESP && (d_rsp_q.err || i_rsp_q.err) ##1 st_q == ST_IDLE;
    endproperty
    a_io_narrow: assert property (p_io_narrow) else $error("narrow IO write passed");

    property p_no_ext_off;
        !external_bus_present |-> !tgt_sel_q[bus_switch_pkg::T_EXT];
    endproperty
    a_no_ext_off: assert property (p_no_ext_off) else $error("absent external selected");

    property p_internal_instr_memory_window;
        tgt_sel_q[bus_switch_pkg::T_INTERNAL_INSTR_MEMORY]
            |-> bus_switch_pkg::in_window(tgt_req_q.addr, ispace_base, internal_instr_mem_bytes);
    endproperty
    a_internal_instr_memory_window: assert property (p_internal_instr_memory_window) else $error("internal_instr_memory outside window");

    property p_answer_back;
        s_busy_done |=> st_q == ST_RESP && (owner_data_q ? d_rsp_q.ack : i_rsp_q.ack)
            ##1 st_q == ST_IDLE && !d_rsp_q.ack && !i_rsp_q.ack;
    endproperty
    a_answer_back: assert property (p_answer_back) else $error("answer not returned");

    property p_io_fixed;
        tgt_sel_q[bus_switch_pkg::T_IO] |-> tgt_req_q.addr >= bus_switch_pkg::IO_BASE;
    endproperty
    a_io_fixed: assert property (p_io_fixed) else $error("IO outside fixed region");
endmodule : address_decode_bus_switch

// ---- hw/address_decoder.sv ----
// Address decoder: picks one target or a fault
`timescale 1ns/1ps
module address_decoder #(
    parameter logic [31:0] ispace_base = bus_switch_pkg::ISPACE_BASE_DEF,
    parameter logic [31:0] dspace_base = bus_switch_pkg::DSPACE_BASE_DEF,
    parameter logic [31:0] internal_instr_mem_bytes = bus_switch_pkg::INTERNAL_INSTR_MEMORY_BYTES_DEF,
    parameter logic [31:0] internal_data_mem_bytes = bus_switch_pkg::INTERNAL_DATA_MEMORY_BYTES_DEF,
    parameter bit internal_instr_mem_present = 1'b0,
    parameter bit internal_data_mem_present = 1'b0,
    parameter bit external_bus_present = 1'b0,
    parameter bit boot_rom_present = 1'b1,
    parameter bit execute_in_place_unit = 1'b0,
    parameter logic [31:0] xip_base = 32'h2000_0000,
    parameter logic [31:0] xip_bytes = 32'h1000_0000,
    parameter logic [15:0] io_slot_present = 16'hFFFF
) (
    input wire logic [31:0] addr,
    input wire logic we,
    input wire logic [3:0] be,
    output logic [bus_switch_pkg::NUM_TGT-1:0] sel,
    output logic fault
);
    // End of the instruction memory, start of the dead gap
    localparam logic [31:0] INTERNAL_INSTR_MEMORY_END = ispace_base + internal_instr_mem_bytes;

    // Priority: fixed regions first, so nothing can shadow them
    always_comb begin
        sel = '0;
        fault = 1'b0;
        if (addr >= bus_switch_pkg::IO_BASE) begin
            // 32-byte aligned slots, one per device
            if (io_slot_present[addr[bus_switch_pkg::IO_SLOT_LSB +: bus_switch_pkg::IO_SLOT_W]]
                && !(we && be != bus_switch_pkg::BE_WORD)) begin
                sel[bus_switch_pkg::T_IO] = 1'b1;
            end else begin
                fault = 1'b1;
            end
        end else if (addr >= bus_switch_pkg::BOOT_BASE) begin
            // Absent ROM still owns its window
            if (boot_rom_present) begin
                sel[bus_switch_pkg::T_BOOT] = 1'b1;
            end else begin
                fault = 1'b1;
            end
        end else if (internal_instr_mem_present
            && bus_switch_pkg::in_window(addr, ispace_base, internal_instr_mem_bytes)) begin
            sel[bus_switch_pkg::T_INTERNAL_INSTR_MEMORY] = 1'b1;
        end else if (internal_data_mem_present
            && bus_switch_pkg::in_window(addr, dspace_base, internal_data_mem_bytes)) begin
            sel[bus_switch_pkg::T_INTERNAL_DATA_MEMORY] = 1'b1;
        end else if (execute_in_place_unit
            && bus_switch_pkg::in_window(addr, xip_base, xip_bytes)) begin
            sel[bus_switch_pkg::T_XIP] = 1'b1;
        end else if (internal_instr_mem_present && ispace_base < dspace_base
            && addr >= INTERNAL_INSTR_MEMORY_END && addr < dspace_base) begin
            fault = 1'b1;
        end else if (external_bus_present) begin
            sel[bus_switch_pkg::T_EXT] = 1'b1;
        end else begin
            fault = 1'b1;
        end
    end
endmodule : address_decoder

// ---- hw/bus_switch_pkg.sv ----
// Shared types, address map and register map of the bus switch and address decoder
package bus_switch_pkg;

    // One CPU or target request
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0] be;
        logic we;
    } bus_req_t;

    // One target or CPU response
    typedef struct packed {
        logic [31:0] rdata;
        logic ack;
        logic err;
    } bus_rsp_t;

    // Address map
    localparam logic [31:0] ISPACE_BASE_DEF = 32'h0000_0000;
    localparam logic [31:0] DSPACE_BASE_DEF = 32'h8000_0000;
    localparam logic [31:0] INTERNAL_INSTR_MEMORY_BYTES_DEF = 32'h0000_4000;
    localparam logic [31:0] INTERNAL_DATA_MEMORY_BYTES_DEF = 32'h0000_2000;
    localparam logic [31:0] BOOT_BASE = 32'hFFFF_0000;
    localparam logic [31:0] IO_BASE = 32'hFFFF_FE00;
    localparam int IO_SLOT_LSB = 5;
    localparam int IO_SLOT_W = 4;
    localparam logic [3:0] BE_WORD = 4'hF;

    // Target select positions
    localparam int T_INTERNAL_INSTR_MEMORY = 0;
    localparam int T_INTERNAL_DATA_MEMORY = 1;
    localparam int T_BOOT = 2;
    localparam int T_IO = 3;
    localparam int T_EXT = 4;
    localparam int T_XIP = 5;
    localparam int NUM_TGT = 6;

    // Register map and fields
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_FSTAT = 8'h04;
    localparam logic [7:0] REG_FADDR = 8'h08;
    localparam logic [7:0] REG_GCNT = 8'h0C;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    localparam int CTRL_FETCH_EN = 0;
    localparam int FSTAT_SEEN = 0;
    localparam int FSTAT_WRITE = 1;
    localparam int FSTAT_FETCH = 2;

    // Address falls inside a window; wraps so a window may straddle zero
    function automatic logic in_window(logic [31:0] addr, logic [31:0] base, logic [31:0] bytes);
        logic [31:0] off;
        off = addr - base;
        return off < bytes;
    endfunction : in_window

endpackage : bus_switch_pkg

// ---- hw/switch_arbiter.sv ----
// Fixed-priority arbiter of the fetch and data ports
`timescale 1ns/1ps
module switch_arbiter (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic idle,
    input wire logic d_valid,
    input wire logic i_valid,
    input wire logic i_allow,
    output logic start,
    output logic start_data,
    output logic owner_data_q
);
    // Data first, fetch only when software lets it through
    always_comb begin
        start_data = d_valid;
        start = idle && (d_valid || (i_valid && i_allow));
    end

    // Owner latched only from the idle state, so it holds for the whole access
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            owner_data_q <= 1'b0;
        end else if (start) begin
            owner_data_q <= start_data;
        end
    end
endmodule : switch_arbiter

// ---- verification/address_decode_bus_switch_tb_top.sv ----
// Self-checking bench of the bus switch and address decoder
`timescale 1ns/1ps
module address_decode_bus_switch_tb_top;
    localparam logic [5:0] IM = 6'h01, DM = 6'h02, BT = 6'h04, IOS = 6'h08, EX = 6'h10;
    // One map probe: port, address, direction, strobes, select, fault
    typedef struct packed {
        logic f;
        logic [31:0] a;
        logic w;
        logic [3:0] be;
        logic [5:0] s;
        logic e;
    } probe_t;
    logic hclk, hresetn, i_valid, d_valid, hsel, hwrite, hready, hreadyout, hresp, err_on;
    bus_switch_pkg::bus_req_t i_req, d_req, tgt_req;
    bus_switch_pkg::bus_rsp_t i_rsp, d_rsp, tgt_rsp [bus_switch_pkg::NUM_TGT];
    logic [5:0] tgt_sel;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] lat;
    int n_fail, n_compared, n_routed;
    probe_t tbl [15];
    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;
    // Both memories and external bus built, IO slot 0 left out
    address_decode_bus_switch #(.internal_instr_mem_present(1'b1),
        .internal_data_mem_present(1'b1), .external_bus_present(1'b1),
        .io_slot_present(16'hFFFE)) DUT (.hclk(hclk), .hresetn(hresetn),
        .i_valid(i_valid), .i_req(i_req), .i_rsp(i_rsp), .d_valid(d_valid),
        .d_req(d_req), .d_rsp(d_rsp), .tgt_req(tgt_req), .tgt_sel(tgt_sel),
        .tgt_rsp(tgt_rsp), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata));
    tgt_model targets (.hclk(hclk), .hresetn(hresetn), .tgt_sel(tgt_sel),
        .tgt_req(tgt_req), .lat(lat), .err_on(err_on), .tgt_rsp(tgt_rsp));
    // Counted compare, four-state exact
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Raise a request; caller picks the edge
    task automatic start(input logic f, input logic [31:0] a, input logic w, input logic [3:0] be);
        if (f) begin
            i_valid <= 1'b1;
            i_req <= '{a, ~a, be, w};
        end else begin
            d_valid <= 1'b1;
            d_req <= '{a, ~a, be, w};
        end
    endtask : start
    // Hold until the answer, then drop and judge it
    task automatic finish(input logic f, input logic [5:0] es, input logic ee);
        bus_switch_pkg::bus_rsp_t r;
        logic [5:0] seen;
        int n;
        seen = '0;
        n = 0;
        r = '0;
        while (r.ack !== 1'b1 && r.err !== 1'b1 && n < 40) begin
            @(posedge hclk);
            seen |= tgt_sel;
            r = f ? i_rsp : d_rsp;
            n++;
        end
        // Answer taken at the edge that samples it; request dropped at that same edge
        i_valid <= f ? 1'b0 : i_valid;
        d_valid <= f ? d_valid : 1'b0;
        chk("answer", 32'h1, {31'h0, r.ack | r.err});
        chk("fault", {31'h0, ee}, {31'h0, r.err});
        chk("select", {26'h0, es}, {26'h0, seen});
        if (!ee) begin
            n_routed++;
            chk("read data", f ? ~i_req.addr : ~d_req.addr, r.rdata);
        end
    endtask : finish
    // One whole CPU access
    task automatic acc(input probe_t p);
        @(posedge hclk);
        start(p.f, p.a, p.w, p.be);
        finish(p.f, p.s, p.e);
    endtask : acc
    // Bounded wait for ready at a rising edge
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        chk("ready", 32'h1, {31'h0, hready});
    endtask : wait_ready
    // Single AHB word transfer; read data lands in rd
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        chk("okay response", 32'h0, {31'h0, hresp});
    endtask : ahb
    // Closing report and verdict
    task automatic give_verdict;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict
    // 50 MHz clock
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    // Hang guard, far beyond the 140 or so cycles the tests need
    initial begin
        repeat (20000) @(posedge hclk);
        n_fail++;
        $display("watchdog expired");
        give_verdict();
    end
    // Main sequence
    initial begin
        {hresetn, i_valid, d_valid, hsel, hwrite, err_on} = '0;
        {i_req, d_req, haddr, hwdata, htrans, lat} = '0;
        {n_fail, n_compared, n_routed} = '0;
        hsize = 3'h2;
        tbl = '{'{1'b1, 32'h0000_0000, 1'b0, 4'hF, IM, 1'b0},
            '{1'b1, 32'h0000_3FFC, 1'b0, 4'hF, IM, 1'b0},
            '{1'b0, 32'h0000_4000, 1'b0, 4'hF, 6'h00, 1'b1},
            '{1'b0, 32'h7FFF_FFFC, 1'b1, 4'hF, 6'h00, 1'b1},
            '{1'b0, 32'h8000_0000, 1'b1, 4'h1, DM, 1'b0},
            '{1'b0, 32'h8000_1FFC, 1'b0, 4'hF, DM, 1'b0},
            '{1'b0, 32'h8000_2000, 1'b1, 4'h3, EX, 1'b0},
            '{1'b1, 32'hFFFF_0000, 1'b0, 4'hF, BT, 1'b0},
            '{1'b0, 32'hFFFF_FDFC, 1'b1, 4'hF, BT, 1'b0},
            '{1'b0, 32'hFFFF_FE20, 1'b1, 4'hF, IOS, 1'b0},
            '{1'b0, 32'hFFFF_FE3C, 1'b0, 4'h1, IOS, 1'b0},
            '{1'b0, 32'hFFFF_FFFC, 1'b0, 4'hC, IOS, 1'b0},
            '{1'b0, 32'hFFFF_FE24, 1'b1, 4'h3, 6'h00, 1'b1},
            '{1'b1, 32'hFFFF_FE00, 1'b0, 4'hF, 6'h00, 1'b1},
            '{1'b0, 32'hFFFF_FE04, 1'b1, 4'hF, 6'h00, 1'b1}};
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, bus_switch_pkg::REG_CTRL, 32'h0);
        chk("control reset", bus_switch_pkg::CTRL_RST, rd);
        $display("test registers at reset done");
        // Map walk at varied target latency
        for (int k = 0; k < 15; k++) begin
            lat <= 4'(k % 3);
            acc(tbl[k]);
        end
        $display("test address map done");
        // Both ports at one edge: data first, fetch waits its turn
        @(posedge hclk);
        start(1'b0, 32'h8000_0010, 1'b0, 4'hF);
        start(1'b1, 32'h0000_0010, 1'b0, 4'hF);
        finish(1'b0, DM, 1'b0);
        finish(1'b1, IM, 1'b0);
        $display("test priority done");
        // Fault record and counters
        ahb(1'b0, bus_switch_pkg::REG_FSTAT, 32'h0);
        chk("fault status", 32'h3, rd);
        ahb(1'b0, bus_switch_pkg::REG_FADDR, 32'h0);
        chk("fault address", 32'hFFFF_FE04, rd);
        ahb(1'b0, bus_switch_pkg::REG_GCNT, 32'h0);
        chk("routed count", 32'(n_routed), rd);
        ahb(1'b1, bus_switch_pkg::REG_FSTAT, 32'h1);
        ahb(1'b0, bus_switch_pkg::REG_FSTAT, 32'h0);
        chk("fault cleared", 32'h0, {31'h0, rd[0]});
        ahb(1'b0, 8'h10, 32'h0);
        chk("unmapped read", 32'h0, rd);
        $display("test status registers done");
        // Fetch gate closed: a waiting fetch must not be taken until reopened
        ahb(1'b1, bus_switch_pkg::REG_CTRL, 32'h0);
        @(posedge hclk);
        start(1'b1, 32'h0000_0020, 1'b0, 4'hF);
        repeat (6) @(posedge hclk);
        chk("gated fetch", 32'h0, {26'h0, tgt_sel});
        ahb(1'b1, bus_switch_pkg::REG_CTRL, 32'h1);
        finish(1'b1, IM, 1'b0);
        $display("test fetch gate done");
        // Target error comes back to the requester
        err_on <= 1'b1;
        acc('{1'b0, 32'h9000_0000, 1'b0, 4'hF, EX, 1'b1});
        ahb(1'b0, bus_switch_pkg::REG_FADDR, 32'h0);
        chk("error address", 32'h9000_0000, rd);
        $display("test target error done");
        give_verdict();
    end
endmodule : address_decode_bus_switch_tb_top

// ---- verification/tgt_model.sv ----
// Behavioural targets that answer the switch's shared bus
`timescale 1ns/1ps
module tgt_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [5:0] tgt_sel,
    input wire bus_switch_pkg::bus_req_t tgt_req,
    input wire logic [3:0] lat,
    input wire logic err_on,
    output bus_switch_pkg::bus_rsp_t tgt_rsp [bus_switch_pkg::NUM_TGT]
);
    logic [3:0] cnt_q; // Cycles spent selected
    logic [31:0] junk_q; // Noise shown while no answer stands
    logic done; // Selected target answers now
    assign done = |tgt_sel && cnt_q == lat;
    // Wait counter, cleared as each access ends
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 4'h0;
            junk_q <= 32'h0;
        end else begin
            cnt_q <= (done || !(|tgt_sel)) ? 4'h0 : cnt_q + 4'h1;
            junk_q <= junk_q + 32'h9E37_79B9;
        end
    end
    // Only the selected target answers; stale data never looks valid
    always_comb begin
        for (int k = 0; k < bus_switch_pkg::NUM_TGT; k++) begin
            tgt_rsp[k].ack = done && tgt_sel[k] && !err_on;
            tgt_rsp[k].err = done && tgt_sel[k] && err_on;
            tgt_rsp[k].rdata = (done && tgt_sel[k]) ? ~tgt_req.addr : junk_q;
        end
    end
endmodule : tgt_model
